/* File: dv/floppy_drive_model.sv */
// drives on the cable: media sense codes, shared with the rate outputs
// assumes the controller drives a sense pin only while its enable is low
`timescale 1ns/1ps
module floppy_drive_model #(
  parameter logic [1:0] SENSE   = 2'b10, // sense code of drives 0 and 1
  parameter logic [1:0] SHSENSE = 2'b01  // sense code on the shared port
) (
  input  wire logic [1:0] dataRateOut,   // controller rate value
  input  wire logic [1:0] dataRateOeN,   // low while controller drives
  output logic      [1:0] mediaSenseIn,  // resolved sense pins
  output logic      [1:0] sharedSenseIn  // shared-port sense pins
);
  // a pin the controller drives carries its value, else the drive code
  assign mediaSenseIn[0] = dataRateOeN[0] ? SENSE[0] : dataRateOut[0];
  assign mediaSenseIn[1] = dataRateOeN[1] ? SENSE[1] : dataRateOut[1];
  assign sharedSenseIn   = SHSENSE;
endmodule : floppy_drive_model

/* File: dv/floppy_pin_control_tb_top.sv */
// self-checking bench for the floppy pin block
// assumes the drive model on the sense pins and an APB slave on clk
`timescale 1ns/1ps
`include "floppy_pin_cfg.svh"
module floppy_pin_control_tb_top;
  import floppy_pin_pkg::*;
  logic         clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic   [7:0] paddr = 8'h00;
  word_t        pwdata = 32'h0000_0000, prdata, rd;
  logic         pready, pslverr, err, masterResetIn = 0, identStrapIn = 1;
  logic         strapLevel = 1, execDone = 0, dataReady = 0, nonDmaMode = 0;
  logic         fdcIrqAck = 0, ctrlIdle = 1, printerOrDrive = 1;
  logic         encodingPinOut, encodingPinOeN, ctrlIdleReq, floppyIrq, irq;
  logic         sharedMotorN, powerdownPin, idlePin;
  logic   [1:0] motorEnableN, mediaSenseIn, dataRateOut, dataRateOeN;
  logic   [1:0] sharedSenseIn;
  wire          encPin;
  compat_mode_t compatMode;
  int           n_mismatch = 0, comparisons = 0;
  localparam logic [7:0] RA[12] = '{`OFS_DIGOUT, `OFS_DSR, `OFS_CFGCTL,
    `OFS_FUNCEN, `OFS_FUNCCTL, `OFS_PWRCTL, `OFS_PWRTEST, `OFS_MODECMD,
    `OFS_CFGCMD, `OFS_LOCKCMD, `OFS_SPECIFY, `OFS_IRQMASK};
  localparam logic [7:0] PA[4] = '{`OFS_DSR, `OFS_FUNCEN, `OFS_PWRTEST,
    `OFS_MODECMD};
  localparam logic [7:0] PV[4] = '{8'h40, 8'h08, 8'h01, 8'h01};

  always #2 clk = ~clk;
  // strap level shows while the encoding pin is not driven
  assign encPin = encodingPinOeN ? strapLevel : encodingPinOut;

  floppy_pin_control floppy_pin_control_i (.clk, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .masterResetIn,
    .identStrapIn, .encodingPinIn(encPin), .encodingPinOut, .encodingPinOeN,
    .execDone, .dataReady, .nonDmaMode, .fdcIrqAck, .ctrlIdle, .ctrlIdleReq,
    .floppyIrq, .irq, .motorEnableN, .sharedMotorN, .printerOrDrive,
    .mediaSenseIn, .dataRateOut, .dataRateOeN, .sharedSenseIn, .powerdownPin,
    .idlePin, .compatMode);
  floppy_drive_model floppy_drive_model_i (.dataRateOut, .dataRateOeN,
    .mediaSenseIn, .sharedSenseIn);

  task chk(input string name, input word_t got, input word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input word_t d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input word_t d);
    apb(1'b1, a, d);
  endtask : wr

  task rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rdr

  task wt;
    repeat (8) @(posedge clk);
  endtask : wt

  // one-cycle pulse of the controller events or the acknowledge
  task ev(input logic e, input logic d, input logic k);
    @(posedge clk);
    execDone  <= e;
    dataReady <= d;
    fdcIrqAck <= k;
    @(posedge clk);
    execDone  <= 1'b0;
    dataReady <= 1'b0;
    fdcIrqAck <= 1'b0;
    wt();
  endtask : ev

  task mreset;
    wt();
    masterResetIn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("motors in reset", motorEnableN, 2'b11);
    chk("idle request", ctrlIdleReq, 1'b1);
    chk("encoding oe", encodingPinOeN, 1'b1);
    masterResetIn <= 1'b0;
    wt();
  endtask : mreset

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      rdr(RA[i]);
      chk("reset value", rd, 32'h0000_0000);
    end
    rdr(8'h3C);
    chk("unmapped", err, 1'b1);
    rdr(`OFS_STATUS);
    chk("mode", rd[1:0], MODE_FIRST);
    $display("test reset done");
    wr(`OFS_DIGOUT, 32'h0000_0030);
    wt();
    chk("motor both", motorEnableN, 2'b00);
    wr(`OFS_DIGOUT, 32'h0000_0010);
    wt();
    chk("motor 0", motorEnableN, 2'b10);
    wr(`OFS_FUNCCTL, 32'h0000_0010);
    wt();
    chk("motor swap", motorEnableN, 2'b01);
    wr(`OFS_FUNCCTL, 32'h0000_0000);
    wr(`OFS_FUNCEN, 32'h0000_0010);
    wr(`OFS_DIGOUT, 32'h0000_0042);
    wt();
    chk("four drive 2", motorEnableN, 2'b01);
    wr(`OFS_DIGOUT, 32'h0000_0012);
    wt();
    chk("four drive off", motorEnableN, 2'b11);
    wr(`OFS_FUNCEN, 32'h0000_0000);
    wr(`OFS_FUNCCTL, 32'h0000_0004);
    printerOrDrive <= 1'b0;
    wr(`OFS_DIGOUT, 32'h0000_0020);
    wt();
    chk("shared motor 1", sharedMotorN, 1'b0);
    rdr(`OFS_STATUS);
    chk("shared sense", rd[5:4], 2'b01);
    wr(`OFS_FUNCCTL, 32'h0000_0014);
    wt();
    chk("shared swap off", sharedMotorN, 1'b1);
    wr(`OFS_DIGOUT, 32'h0000_0010);
    wt();
    chk("shared swap on", sharedMotorN, 1'b0);
    printerOrDrive <= 1'b1;
    wt();
    chk("printer motor", sharedMotorN, 1'b1);
    rdr(`OFS_STATUS);
    chk("printer sense", rd[5:4], 2'b00);
    wr(`OFS_FUNCCTL, 32'h0000_0000);
    wr(`OFS_DIGOUT, 32'h0000_0000);
    rdr(`OFS_STATUS);
    chk("sense in", rd[3:2], 2'b10);
    chk("sense oe", dataRateOeN, 2'b11);
    wr(`OFS_DSR, 32'h0000_0001);
    wr(`OFS_FUNCCTL, 32'h0000_0001);
    wt();
    chk("rate oe", dataRateOeN, 2'b00);
    chk("rate out", mediaSenseIn, 2'b01);
    rdr(`OFS_STATUS);
    chk("sense off", rd[3:2], 2'b00);
    wr(`OFS_FUNCCTL, 32'h0000_0000);
    wr(`OFS_DSR, 32'h0000_0000);
    $display("test pins done");
    wr(`OFS_DIGOUT, 32'h0000_0008);
    ev(1'b1, 1'b0, 1'b0);
    chk("irq exec", floppyIrq, 1'b1);
    chk("irq masked", irq, 1'b0);
    ev(1'b0, 1'b0, 1'b1);
    chk("irq ack", floppyIrq, 1'b0);
    ev(1'b0, 1'b1, 1'b0);
    chk("irq dma", floppyIrq, 1'b0);
    nonDmaMode <= 1'b1;
    ev(1'b0, 1'b1, 1'b0);
    chk("irq nondma", floppyIrq, 1'b1);
    ev(1'b0, 1'b0, 1'b1);
    wr(`OFS_DIGOUT, 32'h0000_0000);
    ev(1'b1, 1'b0, 1'b0);
    chk("irq gated", floppyIrq, 1'b0);
    ev(1'b0, 1'b0, 1'b1);
    wr(`OFS_IRQMASK, 32'h0000_0001);
    wt();
    chk("irq unmasked", irq, 1'b1);
    rdr(`OFS_IRQSTAT);
    chk("irq status", rd[0], 1'b1);
    wt();
    chk("irq cleared", irq, 1'b0);
    $display("test interrupt done");
    wr(`OFS_PWRCTL, 32'h0000_0010);
    ctrlIdle <= 1'b0;
    wt();
    chk("pwdn low", powerdownPin, 1'b0);
    chk("busy", idlePin, 1'b0);
    ctrlIdle <= 1'b1;
    wt();
    chk("idle", idlePin, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(PA[i], PV[i]);
      wt();
      chk("pwdn source", powerdownPin, 1'b1);
      wr(PA[i], 32'h0000_0000);
    end
    wr(`OFS_PWRCTL, 32'h0000_0000);
    wr(`OFS_DIGOUT, 32'h0000_0021);
    wt();
    chk("drive select 1", powerdownPin, 1'b0);
    chk("idle as motor", idlePin, 1'b0);
    wr(`OFS_MODECMD, 32'h0000_0002);
    wt();
    chk("encoding out", encodingPinOut, 1'b1);
    chk("encoding oe on", encodingPinOeN, 1'b0);
    $display("test power done");
    wr(`OFS_SPECIFY, 32'h0000_1234);
    wr(`OFS_FUNCEN, 32'h0000_0010);
    identStrapIn <= 1'b0;
    mreset();
    chk("encoding dflt", encodingPinOut, 1'b0);
    rdr(`OFS_DIGOUT);
    chk("digout cleared", rd, 32'h0000_0000);
    rdr(`OFS_MODECMD);
    chk("mode cleared", rd, 32'h0000_0000);
    rdr(`OFS_FUNCEN);
    chk("config dflt", rd, 32'h0000_0000);
    rdr(`OFS_SPECIFY);
    chk("specify kept", rd, 32'h0000_1234);
    rdr(`OFS_STATUS);
    chk("mode second", rd[1:0], MODE_SECOND);
    ev(1'b1, 1'b0, 1'b0);
    chk("irq always", floppyIrq, 1'b1);
    ev(1'b0, 1'b0, 1'b1);
    strapLevel <= 1'b0;
    mreset();
    rdr(`OFS_STATUS);
    chk("mode third", rd[1:0], MODE_THIRD);
    ev(1'b1, 1'b0, 1'b0);
    chk("irq gated 3", floppyIrq, 1'b0);
    $display("test master reset done");
    stop_test();
  end
endmodule : floppy_pin_control_tb_top

/* File: pkg/floppy_pin_cfg.svh */
// register offsets, field positions and reset values of the floppy pin block
// assumes an APB slave with byte addresses in an 8-bit window
`ifndef FLOPPY_PIN_CFG_SVH
`define FLOPPY_PIN_CFG_SVH

`define OFS_DIGOUT     8'h00
`define OFS_DSR        8'h04
`define OFS_CFGCTL     8'h08
`define OFS_FUNCEN     8'h0C
`define OFS_FUNCCTL    8'h10
`define OFS_PWRCTL     8'h14
`define OFS_PWRTEST    8'h18
`define OFS_MODECMD    8'h1C
`define OFS_CFGCMD     8'h20
`define OFS_LOCKCMD    8'h24
`define OFS_SPECIFY    8'h28
`define OFS_STATUS     8'h2C
`define OFS_IRQSTAT    8'h30
`define OFS_IRQMASK    8'h34

`define RST_DIGOUT     8'h00
`define RST_DSR        8'h00
`define RST_CFGCTL     8'h00
`define RST_FUNCEN     8'h00
`define RST_FUNCCTL    8'h00
`define RST_PWRCTL     8'h00
`define RST_PWRTEST    8'h00
`define RST_MODECMD    8'h00
`define RST_CFGCMD     8'h00
`define RST_LOCKCMD    8'h00
`define RST_SPECIFY    16'h0000

`define DIGOUT_IRQ_EN  3
`define DIGOUT_MOTOR   4
`define DSR_PWDN       6
`define FUNCEN_FOUR    4
`define FUNCEN_PWDN    3
`define FUNCCTL_SWAP   4
`define FUNCCTL_SHARE  2
`define FUNCCTL_RATE   0
`define PWRCTL_ALT     4
`define PWRTEST_PWDN   0
`define MODE_PWDN      0
`define MODE_ENC       1

`define IRQ_FDC        0
`define IRQ_MRESET     1
`define IRQ_PWDN       2

`define SY_MRESET      0
`define SY_IDENT       1
`define SY_ENC         2
`define SY_PORTSEL     3
`define SY_SENSE       4
`define SY_SHSENSE     6
`define SY_W           8

`endif

/* File: pkg/floppy_pin_pkg.sv */
// types shared by the floppy pin block and its bench
// assumes floppy_pin_cfg.svh holds all offsets and reset values
package floppy_pin_pkg;
  typedef enum logic [1:0] {
    MODE_FIRST,
    MODE_SECOND,
    MODE_THIRD
  } compat_mode_t;
  typedef logic [7:0]  reg8_t;
  typedef logic [31:0] word_t;
endpackage : floppy_pin_pkg

/* File: verilog/floppy_pin_control.sv */
// pin-level control of a floppy controller: interrupt gating, master reset,
// mode strap, encoding pin, motor routing, media sense and power pins
// assumes an APB master on clk and controller event pulses on clk
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "floppy_pin_cfg.svh"

module floppy_pin_control (
  input  wire logic                       clk,           // 250 MHz clock
  input  wire logic                       rst,           // async reset
  input  wire logic [7:0]                 paddr,         // apb address
  input  wire logic                       psel,          // apb select
  input  wire logic                       penable,       // apb enable
  input  wire logic                       pwrite,        // apb direction
  input  wire floppy_pin_pkg::word_t      pwdata,        // apb write data
  output floppy_pin_pkg::word_t           prdata,        // apb read data
  output logic                            pready,        // apb ready
  output logic                            pslverr,       // unmapped address
  input  wire logic                       masterResetIn, // master reset pin
  input  wire logic                       identStrapIn,  // interface strap
  input  wire logic                       encodingPinIn, // encoding pin in
  output logic                            encodingPinOut,// encoding pin out
  output logic                            encodingPinOeN,// low while driving
  input  wire logic                       execDone,      // command finished
  input  wire logic                       dataReady,     // transfer ready
  input  wire logic                       nonDmaMode,    // no dma in use
  input  wire logic                       fdcIrqAck,     // clears interrupt
  input  wire logic                       ctrlIdle,      // controller idle
  output logic                            ctrlIdleReq,   // force idle state
  output logic                            floppyIrq,     // floppy interrupt
  output logic                            irq,           // register irq
  output logic [1:0]                      motorEnableN,  // motor pins, low on
  output logic                            sharedMotorN,  // shared-port motor
  input  wire logic                       printerOrDrive,// shared-port select
  input  wire logic [1:0]                 mediaSenseIn,  // media sense pins
  output logic [1:0]                      dataRateOut,   // rate on those pins
  output logic [1:0]                      dataRateOeN,   // low while driving
  input  wire logic [1:0]                 sharedSenseIn, // shared sense pins
  output logic                            powerdownPin,  // power-down pin
  output logic                            idlePin,       // idle pin
  output floppy_pin_pkg::compat_mode_t    compatMode     // selected mode
);
  import floppy_pin_pkg::*;

  // three-stage synchronisers with agreement filter
  logic [`SY_W-1:0] syA;
  logic [`SY_W-1:0] syB;
  logic [`SY_W-1:0] syC;
  logic [`SY_W-1:0] pinLvl;
  wire  [`SY_W-1:0] rawPins = {sharedSenseIn, mediaSenseIn, printerOrDrive,
                               encodingPinIn, identStrapIn, masterResetIn};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syA    <= '0;
      syB    <= '0;
      syC    <= '0;
      pinLvl <= '0;
    end else begin
      syA    <= rawPins;
      syB    <= syA;
      syC    <= syB;
      pinLvl <= (syB & syC) | (pinLvl & (syB ^ syC));
    end
  end

  wire       mresetLvl  = pinLvl[`SY_MRESET];
  wire       identLvl   = pinLvl[`SY_IDENT];
  wire       encLvl     = pinLvl[`SY_ENC];
  wire       portSelLvl = pinLvl[`SY_PORTSEL];
  wire [1:0] senseLvl = pinLvl[`SY_SENSE +: 2];
  wire [1:0] shSense  = pinLvl[`SY_SHSENSE +: 2];

  // registers
  reg8_t        digitalOutputReg;
  reg8_t        dataRateReg;
  reg8_t        configControlReg;
  reg8_t        functionEnableReg;
  reg8_t        functionControlReg;
  reg8_t        powerManagementControlReg;
  reg8_t        powerTestReg;
  reg8_t        modeCmdReg;
  reg8_t        cfgCmdReg;
  reg8_t        lockCmdReg;
  logic [15:0]  specifyReg;
  logic [2:0]   irqStatus;
  logic [2:0]   irqMask;
  logic         floppyPending;
  logic         pwdnLast;
  logic         mresetLast;

  // apb decode
  wire setupPh  = psel & ~penable;
  wire accessOk = psel & penable & pready;
  wire wrEn     = accessOk & pwrite;
  wire rdEn     = accessOk & ~pwrite;
  wire hitDigOut  = paddr == `OFS_DIGOUT;
  wire hitDsr     = paddr == `OFS_DSR;
  wire hitCfgCtl  = paddr == `OFS_CFGCTL;
  wire hitFuncEn  = paddr == `OFS_FUNCEN;
  wire hitFuncCtl = paddr == `OFS_FUNCCTL;
  wire hitPwrCtl  = paddr == `OFS_PWRCTL;
  wire hitPwrTest = paddr == `OFS_PWRTEST;
  wire hitMode  = paddr == `OFS_MODECMD;
  wire hitCfg   = paddr == `OFS_CFGCMD;
  wire hitLock  = paddr == `OFS_LOCKCMD;
  wire hitSpec  = paddr == `OFS_SPECIFY;
  wire hitStat  = paddr == `OFS_STATUS;
  wire hitIrqS  = paddr == `OFS_IRQSTAT;
  wire hitIrqM  = paddr == `OFS_IRQMASK;
  wire hitAny   = hitDigOut | hitDsr | hitCfgCtl | hitFuncEn | hitFuncCtl |
                  hitPwrCtl | hitPwrTest | hitMode | hitCfg | hitLock |
                  hitSpec | hitStat |
                  hitIrqS | hitIrqM;

  // block state seen by logic and status
  wire powerDown = dataRateReg[`DSR_PWDN] | functionEnableReg[`FUNCEN_PWDN] |
                   powerTestReg[`PWRTEST_PWDN] |
                   modeCmdReg[`MODE_PWDN];
  wire rateOutOn = functionControlReg[`FUNCCTL_RATE];
  wire sharedOn  = functionControlReg[`FUNCCTL_SHARE] & ~portSelLvl;
  wire swapOn    = functionControlReg[`FUNCCTL_SWAP];
  wire pinAlt    = powerManagementControlReg[`PWRCTL_ALT];
  wire [1:0] senseSeen   = rateOutOn ? 2'b00 : senseLvl;
  wire [1:0] shSenseSeen = sharedOn ? shSense : 2'b00;
  wire [7:0] statusWord  = {2'b00, shSenseSeen, senseSeen, compatMode};

  wire [7:0] rd8 =
      hitDigOut  ? digitalOutputReg :
      hitDsr     ? dataRateReg :
      hitCfgCtl  ? configControlReg :
      hitFuncEn  ? functionEnableReg :
      hitFuncCtl ? functionControlReg :
      hitPwrCtl  ? powerManagementControlReg :
      hitPwrTest ? powerTestReg :
      hitMode ? modeCmdReg :
      hitCfg  ? cfgCmdReg :
      hitLock ? lockCmdReg :
      hitStat ? statusWord :
      hitIrqS ? {5'b0_0000, irqStatus} :
      hitIrqM ? {5'b0_0000, irqMask} : 8'h00;
  wire [31:0] rdWord = hitSpec ? {16'h0000, specifyReg} : {24'h00_0000, rd8};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupPh;
      pslverr <= setupPh & ~hitAny;
      if (setupPh) begin
        prdata <= pwrite ? 32'h0000_0000 : rdWord;
      end
    end
  end

  // software and master-reset updates of the register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      digitalOutputReg          <= `RST_DIGOUT;
      dataRateReg               <= `RST_DSR;
      configControlReg          <= `RST_CFGCTL;
      functionEnableReg         <= `RST_FUNCEN;
      functionControlReg        <= `RST_FUNCCTL;
      powerManagementControlReg <= `RST_PWRCTL;
      powerTestReg              <= `RST_PWRTEST;
      modeCmdReg                <= `RST_MODECMD;
      cfgCmdReg                 <= `RST_CFGCMD;
      lockCmdReg                <= `RST_LOCKCMD;
      irqMask                   <= 3'h0;
    end else if (mresetLvl) begin
      digitalOutputReg          <= `RST_DIGOUT;
      dataRateReg               <= `RST_DSR;
      configControlReg          <= `RST_CFGCTL;
      modeCmdReg                <= `RST_MODECMD;
      cfgCmdReg                 <= `RST_CFGCMD;
      lockCmdReg                <= `RST_LOCKCMD;
      functionEnableReg         <= `RST_FUNCEN;
      functionControlReg        <= `RST_FUNCCTL;
      powerManagementControlReg <= `RST_PWRCTL;
      powerTestReg              <= `RST_PWRTEST;
    end else if (wrEn) begin
      if (hitDigOut)  digitalOutputReg          <= pwdata[7:0];
      if (hitDsr)     dataRateReg               <= pwdata[7:0];
      if (hitCfgCtl)  configControlReg          <= pwdata[7:0];
      if (hitFuncEn)  functionEnableReg         <= pwdata[7:0];
      if (hitFuncCtl) functionControlReg        <= pwdata[7:0];
      if (hitPwrCtl)  powerManagementControlReg <= pwdata[7:0];
      if (hitPwrTest) powerTestReg              <= pwdata[7:0];
      if (hitMode) modeCmdReg                <= pwdata[7:0];
      if (hitCfg)  cfgCmdReg                 <= pwdata[7:0];
      if (hitLock) lockCmdReg                <= pwdata[7:0];
      if (hitIrqM) irqMask                   <= pwdata[2:0];
    end
  end

  // specify parameters ride through master reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      specifyReg <= `RST_SPECIFY;
    end else if (wrEn && hitSpec) begin
      specifyReg <= pwdata[15:0];
    end
  end

  // mode strap caught while master reset is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compatMode <= MODE_FIRST;
    end else if (mresetLvl) begin
      compatMode <= identLvl ? MODE_FIRST :
                    (encLvl ? MODE_SECOND : MODE_THIRD);
    end
  end

  // floppy interrupt: sticky until acknowledged, set wins
  wire fdcEvent = execDone | (dataReady & nonDmaMode);
  wire irqGate  = (compatMode == MODE_SECOND) |
                  digitalOutputReg[`DIGOUT_IRQ_EN];
  wire [2:0] irqEvents = {powerDown & ~pwdnLast, mresetLast & ~mresetLvl,
                          fdcEvent & ~mresetLvl};
  wire irqClr = rdEn & hitIrqS;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      floppyPending <= 1'b0;
      floppyIrq     <= 1'b0;
      irqStatus     <= 3'h0;
      irq           <= 1'b0;
      pwdnLast      <= 1'b0;
      mresetLast    <= 1'b0;
    end else begin
      if (mresetLvl) begin
        floppyPending <= 1'b0;
      end else if (fdcEvent) begin
        floppyPending <= 1'b1;
      end else if (fdcIrqAck) begin
        floppyPending <= 1'b0;
      end
      floppyIrq <= floppyPending & irqGate & ~mresetLvl;
      irqStatus <= irqEvents | (irqClr ? 3'h0 : irqStatus);
      irq       <= |(irqStatus & irqMask);
      pwdnLast  <= powerDown;
      mresetLast <= mresetLvl;
    end
  end

  // motor routing
  wire [1:0] drvSel   = digitalOutputReg[1:0];
  wire [3:0] motorBit = digitalOutputReg[`DIGOUT_MOTOR +: 4];
  wire       selMotor = motorBit[drvSel];
  wire [1:0] motorDirect = motorBit[1:0];
  wire [1:0] motorFour   = {selMotor & drvSel[1], selMotor & ~drvSel[1]};
  wire [1:0] motorLogic  = functionEnableReg[`FUNCEN_FOUR] ?
                           motorFour : motorDirect;
  wire [1:0] motorPin    = swapOn ? {motorLogic[0], motorLogic[1]} :
                           motorLogic;
  wire       sharedMotor = sharedOn &
                           (swapOn ? motorBit[0] : motorBit[1]);
  wire       drvSel1N    = ~(drvSel == 2'b01);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motorEnableN   <= 2'b11;
      sharedMotorN   <= 1'b1;
      dataRateOut    <= 2'b00;
      dataRateOeN    <= 2'b11;
      powerdownPin   <= 1'b1;
      idlePin        <= 1'b1;
      ctrlIdleReq    <= 1'b1;
      encodingPinOut <= 1'b0;
      encodingPinOeN <= 1'b1;
    end else if (mresetLvl) begin
      motorEnableN   <= 2'b11;
      sharedMotorN   <= 1'b1;
      dataRateOut    <= 2'b00;
      dataRateOeN    <= 2'b11;
      powerdownPin   <= ~pinAlt;
      idlePin        <= 1'b1;
      ctrlIdleReq    <= 1'b1;
      encodingPinOut <= 1'b0;
      encodingPinOeN <= 1'b1;
    end else begin
      motorEnableN   <= ~motorPin;
      sharedMotorN   <= ~sharedMotor;
      dataRateOut    <= rateOutOn ? dataRateReg[1:0] : 2'b00;
      dataRateOeN    <= {2{~rateOutOn}};
      powerdownPin   <= pinAlt ? powerDown : drvSel1N;
      idlePin        <= pinAlt ? (ctrlIdle | powerDown) :
                        ~motorPin[1];
      ctrlIdleReq    <= 1'b0;
      encodingPinOut <= modeCmdReg[`MODE_ENC];
      encodingPinOeN <= 1'b0;
    end
  end

  // checks
  property p_fdc_event;
    @(posedge clk) disable iff (rst)
    (execDone && !mresetLvl && irqGate ##1
     !mresetLvl && irqGate && !fdcIrqAck)
      |=> floppyIrq;
  endproperty
  a_fdc_event: assert property (p_fdc_event) else $error("irq missed");

  property p_gate;
    @(posedge clk) disable iff (rst)
    (!digitalOutputReg[3] && compatMode != MODE_SECOND) |=> !floppyIrq;
  endproperty
  a_gate: assert property (p_gate) else $error("irq not gated");

  property p_mr_pins;
    @(posedge clk) disable iff (rst)
    mresetLvl |=> (motorEnableN == 2'b11 && sharedMotorN && ctrlIdleReq &&
               dataRateOeN == 2'b11);
  endproperty
  a_mr_pins: assert property (p_mr_pins) else $error("pins active");

  property p_mr_regs;
    @(posedge clk) disable iff (rst)
    mresetLvl |=> (digitalOutputReg == `RST_DIGOUT &&
                   modeCmdReg == `RST_MODECMD);
  endproperty
  a_mr_regs: assert property (p_mr_regs) else $error("regs kept");

  property p_specify;
    @(posedge clk) disable iff (rst)
    (mresetLvl && !(wrEn && hitSpec)) |=> $stable(specifyReg);
  endproperty
  a_specify: assert property (p_specify) else $error("specify lost");

  property p_cfg_def;
    @(posedge clk) disable iff (rst)
    mresetLvl |=> (functionEnableReg == `RST_FUNCEN &&
                   powerManagementControlReg == `RST_PWRCTL);
  endproperty
  a_cfg_def: assert property (p_cfg_def) else $error("cfg kept");

  property p_strap;
    @(posedge clk) disable iff (rst)
    (mresetLvl && !identLvl) |=>
      (compatMode == ($past(encLvl) ? MODE_SECOND : MODE_THIRD));
  endproperty
  a_strap: assert property (p_strap) else $error("bad strap");

  property p_enc_rel;
    @(posedge clk) disable iff (rst)
    $fell(mresetLvl) |=> (!encodingPinOeN && !encodingPinOut);
  endproperty
  a_enc_rel: assert property (p_enc_rel) else $error("enc pin");

  property p_swap;
    @(posedge clk) disable iff (rst)
    (!mresetLvl && swapOn && !functionEnableReg[4]) |=>
      (motorEnableN == ~{$past(motorBit[0]), $past(motorBit[1])});
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_rate;
    @(posedge clk) disable iff (rst)
    (!mresetLvl && rateOutOn) |=> (dataRateOeN == 2'b00);
  endproperty
  a_rate: assert property (p_rate) else $error("rate pins");

  property p_pwdn;
    @(posedge clk) disable iff (rst)
    (!mresetLvl && pinAlt && powerDown) |=> (powerdownPin && idlePin);
  endproperty
  a_pwdn: assert property (p_pwdn) else $error("pwdn pin low");

  c_irq:   cover property (@(posedge clk) disable iff (rst) floppyIrq);
  c_swap:  cover property (@(posedge clk) disable iff (rst)
                           swapOn && motorEnableN != 2'b11);
  c_mode2: cover property (@(posedge clk) disable iff (rst)
                           $fell(mresetLvl) && compatMode == MODE_SECOND);
  c_share: cover property (@(posedge clk) disable iff (rst) !sharedMotorN);

endmodule : floppy_pin_control
